// ==== src/i2c_bus_control_status.sv ====
/*
  Control and status logic of a serial bus interface: transfer pause,
  interface/port mode, two-step soft reset, arbitration monitor,
  address match, general call and last bit monitors, free format.
  Assumes software strobes are one cycle on i_clk and the bus pins are
  open drain, driven low when the matching output enable is high.
*/
`timescale 1ns/1ps
`include "i2c_ctl_map.svh"
module i2c_bus_control_status
  import i2c_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Control register two write
  input  wire logic       i_cr2_wr,
  input  wire logic       i_wr_master_select,
  input  wire logic       i_wr_transmit_select,
  input  wire logic       i_wr_pause,
  input  wire logic       i_wr_iface_mode,
  input  wire logic [1:0] i_wr_soft_reset,
  // Data buffer access
  input  wire logic       i_dbr_wr,
  input  wire logic [7:0] i_dbr_wdata,
  input  wire logic       i_dbr_rd,
  // Control register one and own address
  input  wire logic       i_ack_count_en,
  input  wire logic       i_addr_detect_disable,
  input  wire logic [2:0] i_bit_count_field,
  input  wire logic [2:0] i_clk_period_sel,
  input  wire logic [6:0] i_own_slave_address,
  input  wire logic       i_free_format_select,
  // Bus pins
  input  wire logic       i_scl,
  output logic            o_scl,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Status
  output logic            o_iface_mode_select,
  output logic            o_master_select,
  output logic            o_transmit_select,
  output logic            o_pause_flag,
  output logic            o_arb_lost_flag,
  output logic            o_addressed_as_slave_flag,
  output logic            o_general_call_flag,
  output logic            o_last_rx_bit,
  output logic            o_bus_busy_flag,
  output logic [7:0]      o_rx_data,
  output logic            o_transfer_irq
);

  function automatic period_t low_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    low_cycles = `LOW_N0;
      3'h1:    low_cycles = `LOW_N1;
      3'h2:    low_cycles = `LOW_N2;
      3'h3:    low_cycles = `LOW_N3;
      3'h4:    low_cycles = `LOW_N4;
      3'h5:    low_cycles = `LOW_N5;
      3'h6:    low_cycles = `LOW_N6;
      default: low_cycles = `LOW_N7;
    endcase
  endfunction : low_cycles

  function automatic period_t high_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    high_cycles = `HIGH_M0;
      3'h1:    high_cycles = `HIGH_M1;
      3'h2:    high_cycles = `HIGH_M2;
      3'h3:    high_cycles = `HIGH_M3;
      3'h4:    high_cycles = `HIGH_M4;
      3'h5:    high_cycles = `HIGH_M5;
      3'h6:    high_cycles = `HIGH_M6;
      default: high_cycles = `HIGH_M7;
    endcase
  endfunction : high_cycles

  // Pin sampling
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_ff;
  logic       sda_d_ff;

  i2c_pin_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_scl, i_sda}),
    .o_sync  (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // State
  logic       iface_ff;
  logic       master_ff;
  logic       trx_ff;
  logic       pause_ff;
  logic       pause_d_ff;
  logic       arm_ff;
  logic       al_ff;
  logic       aas_ff;
  logic       gc_ff;
  logic       lrb_ff;
  logic       busy_ff;
  logic       first_ff;
  logic       irq_ff;
  logic       mpull_ff;
  logic       sel_ff;
  phase_e     phase_ff;
  logic [3:0] bit_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] rx_data_ff;
  period_t    low_cnt_ff;
  period_t    high_cnt_ff;

  // Bus events, gated off in port mode
  wire act_w    = iface_ff;
  wire rise_w   = act_w & scl_s & ~scl_d_ff;
  wire fall_w   = act_w & ~scl_s & scl_d_ff;
  wire start_w  = act_w & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_w   = act_w & scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // Software strobes
  wire cr2_ok_w   = i_cr2_wr & iface_ff;
  wire sw_reset_w = cr2_ok_w & arm_ff &
                    (i_wr_soft_reset == `SOFT_RESET_FIELD_FIRE);
  wire set_pause_w = act_w & (i_dbr_wr | (cr2_ok_w & i_wr_pause));
  wire al_clr_w   = i_dbr_wr | i_dbr_rd | i_cr2_wr;
  wire aas_clr_w  = i_dbr_wr | i_dbr_rd;

  // Word framing
  wire [3:0] nbits_w = (i_bit_count_field == 3'h0) ? `WORD_BITS
                                                   : {1'h0, i_bit_count_field};
  wire last_w    = (phase_ff == PH_DATA) & (bit_ff == nbits_w);
  wire eval_w    = fall_w & last_w & first_ff;
  wire match_w   = (rx_sh_ff[7:1] == i_own_slave_address);
  wire gcall_w   = (rx_sh_ff == `GCALL_BYTE);
  wire addr_hit_w = ~i_addr_detect_disable & ~i_free_format_select &
                    ~master_ff & (match_w | gcall_w);
  wire engaged_w = master_ff | al_ff | sel_ff |
                   i_free_format_select | (addr_hit_w & first_ff);
  wire skip_w    = eval_w & ~engaged_w;
  wire word_end_w = engaged_w & fall_w &
                    ((last_w & ~i_ack_count_en) | (phase_ff == PH_ACK));
  wire aas_set_w = (eval_w & addr_hit_w) |
                   (word_end_w & first_ff & i_free_format_select &
                    ~master_ff);
  wire gc_set_w  = eval_w & addr_hit_w & gcall_w;

  // Arbitration: own level against bus level on each data bit rise as master transmitter, every word
  wire al_set_w = rise_w & master_ff & trx_ff & (phase_ff == PH_DATA) &
                  (sda_s != tx_sh_ff[7]);

  // Master clock generation stops once arbitration is lost
  wire gen_w = master_ff & pause_ff & ~al_ff & busy_ff &
               (phase_ff != PH_IDLE);
  wire load_low_w = (pause_ff & ~pause_d_ff) | (fall_w & gen_w);

  // Pin drive; data released after arbitration loss, clock still held while paused
  wire scl_low_w = act_w & (~pause_ff |
                   (busy_ff & ~al_ff &
                    ((low_cnt_ff != 9'h000) | mpull_ff |
                     (pause_ff & ~pause_d_ff))));
  wire sda_low_w = act_w & ~al_ff & (
                   ((phase_ff == PH_DATA) & trx_ff & ~tx_sh_ff[7]) |
                   ((phase_ff == PH_ACK) & ~trx_ff & i_ack_count_en));

  // Next values
  logic nxt_pause;
  logic nxt_al;
  logic nxt_aas;
  logic nxt_gc;
  logic nxt_master;
  logic nxt_trx;

  assign nxt_pause = (set_pause_w | sw_reset_w) ? 1'h1
                   : (word_end_w ? 1'h0 : pause_ff);
  assign nxt_al    = al_set_w | (al_ff & ~al_clr_w);
  assign nxt_aas   = aas_set_w | (aas_ff & ~aas_clr_w);
  assign nxt_gc    = gc_set_w | (gc_ff & ~(start_w | stop_w));

  always_comb begin
    nxt_master = master_ff;
    nxt_trx    = trx_ff;
    if (cr2_ok_w) begin
      nxt_master = i_wr_master_select;
      nxt_trx    = i_wr_transmit_select;
    end
    if (eval_w & addr_hit_w & match_w) begin
      nxt_trx = rx_sh_ff[0];
    end
    if (al_set_w | stop_w | sw_reset_w) begin
      nxt_master = 1'h0;
      nxt_trx    = 1'h0;
    end
  end

  // Control register two; mode bit survives the soft reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      iface_ff  <= 1'h0;
      master_ff <= 1'h0;
      trx_ff    <= 1'h0;
      pause_ff  <= `PAUSE_RST;
      arm_ff    <= 1'h0;
    end else begin
      if (i_cr2_wr) begin
        iface_ff <= i_wr_iface_mode;
      end
      master_ff <= nxt_master;
      trx_ff    <= nxt_trx;
      pause_ff  <= nxt_pause;
      if (cr2_ok_w) begin
        arm_ff <= (i_wr_soft_reset == `SOFT_RESET_FIELD_ARM);
      end
    end
  end

  // Status flags, untouched by the soft reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      al_ff   <= 1'h0;
      aas_ff  <= 1'h0;
      gc_ff   <= 1'h0;
      lrb_ff  <= 1'h0;
      busy_ff <= 1'h0;
    end else begin
      al_ff  <= nxt_al;
      aas_ff <= nxt_aas;
      gc_ff  <= nxt_gc;
      if (rise_w) begin
        lrb_ff <= sda_s;
      end
      if (start_w) begin
        busy_ff <= 1'h1;
      end else if (stop_w) begin
        busy_ff <= 1'h0;
      end
    end
  end

  // Bit engine; free format counts every bit as data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || sw_reset_w) begin
      phase_ff <= PH_IDLE;
      bit_ff   <= 4'h0;
      first_ff <= 1'h0;
      rx_sh_ff <= 8'h00;
    end else if (start_w) begin
      phase_ff <= PH_DATA;
      bit_ff   <= 4'h0;
      first_ff <= 1'h1;
    end else if (stop_w) begin
      phase_ff <= PH_IDLE;
    end else if (rise_w && phase_ff == PH_DATA) begin
      rx_sh_ff <= {rx_sh_ff[6:0], sda_s};
      bit_ff   <= bit_ff + 4'h1;
    end else if (skip_w) begin
      phase_ff <= PH_SKIP;
    end else if (word_end_w) begin
      phase_ff <= PH_DATA;
      bit_ff   <= 4'h0;
      first_ff <= 1'h0;
    end else if (fall_w && last_w) begin
      phase_ff <= PH_ACK;
    end
  end

  // Selected slave stays engaged until the next start or stop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || sw_reset_w || start_w || stop_w) begin
      sel_ff <= 1'h0;
    end else if (eval_w && addr_hit_w) begin
      sel_ff <= 1'h1;
    end
  end

  // Transmit shifter and received word
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_sh_ff   <= 8'hFF;
      rx_data_ff <= 8'h00;
      irq_ff     <= 1'h0;
    end else begin
      if (i_dbr_wr && act_w) begin
        tx_sh_ff <= i_dbr_wdata;
      end else if (fall_w && phase_ff == PH_DATA && !last_w &&
                   bit_ff != 4'h0) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'h1};
      end else if (fall_w && last_w) begin
        tx_sh_ff <= 8'hFF;
      end
      if (word_end_w) begin
        rx_data_ff <= rx_sh_ff;
      end
      irq_ff <= word_end_w;
    end
  end

  // Clock low and high period counters
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || sw_reset_w) begin
      scl_d_ff    <= 1'h1;
      sda_d_ff    <= 1'h1;
      pause_d_ff  <= `PAUSE_RST;
      low_cnt_ff  <= 9'h000;
      high_cnt_ff <= 9'h000;
      mpull_ff    <= 1'h0;
    end else begin
      scl_d_ff   <= scl_s;
      sda_d_ff   <= sda_s;
      pause_d_ff <= pause_ff;
      if (load_low_w) begin
        low_cnt_ff <= low_cycles(i_clk_period_sel) - 9'h001;
      end else if (low_cnt_ff != 9'h000) begin
        low_cnt_ff <= low_cnt_ff - 9'h001;
      end
      if (gen_w && scl_s && !mpull_ff) begin
        high_cnt_ff <= high_cnt_ff + 9'h001;
      end else begin
        high_cnt_ff <= 9'h000;
      end
      if (fall_w || !gen_w) begin
        mpull_ff <= 1'h0;
      end else if (high_cnt_ff == high_cycles(i_clk_period_sel)) begin
        mpull_ff <= 1'h1;
      end
    end
  end

  // Outputs
  assign o_scl    = 1'h0;
  assign o_sda    = 1'h0;
  assign o_scl_oe = scl_low_w;
  assign o_sda_oe = sda_low_w;
  assign o_iface_mode_select       = iface_ff;
  assign o_master_select           = master_ff;
  assign o_transmit_select         = trx_ff;
  assign o_pause_flag              = pause_ff;
  assign o_arb_lost_flag           = al_ff;
  assign o_addressed_as_slave_flag = aas_ff;
  assign o_general_call_flag       = gc_ff;
  assign o_last_rx_bit             = lrb_ff;
  assign o_bus_busy_flag           = busy_ff;
  assign o_rx_data                 = rx_data_ff;
  assign o_transfer_irq            = irq_ff;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_pause_set;
    iface_ff && i_dbr_wr |=> pause_ff ##1 o_scl_oe == 1'h0 || busy_ff;
  endproperty
  a_pause_set: assert property (p_pause_set)
    else $error("data write did not set pause");

  property p_pause_hold;
    pause_ff && !word_end_w |=> pause_ff;
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("pause cleared without word end");

  property p_port_idle;
    !iface_ff |-> !o_scl_oe && !o_sda_oe && !rise_w;
  endproperty
  a_port_idle: assert property (p_port_idle)
    else $error("port mode drives the bus");

  property p_port_write;
    !iface_ff && i_cr2_wr |=> $stable(master_ff) && $stable(trx_ff);
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("control write took effect in port mode");

  property p_soft_reset;
    iface_ff && i_cr2_wr && i_wr_soft_reset == `SOFT_RESET_FIELD_ARM ##1
    !i_cr2_wr ##1 !i_cr2_wr ##1
    iface_ff && i_cr2_wr && i_wr_soft_reset == `SOFT_RESET_FIELD_FIRE
    |=> !master_ff && !trx_ff && pause_ff &&
        iface_ff == $past(i_wr_iface_mode);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset sequence ignored");

  property p_al_set;
    al_set_w |=> al_ff && !master_ff && !trx_ff;
  endproperty
  a_al_set: assert property (p_al_set)
    else $error("arbitration loss not handled");

  property p_al_release;
    al_ff |-> !o_sda_oe && (o_scl_oe == !pause_ff);
  endproperty
  a_al_release: assert property (p_al_release)
    else $error("lost master still drives");

  property p_al_clear;
    al_ff && al_clr_w && !al_set_w |=> !al_ff;
  endproperty
  a_al_clear: assert property (p_al_clear)
    else $error("arbitration flag not cleared");

  property p_gc_clear;
    start_w || stop_w |=> !gc_ff;
  endproperty
  a_gc_clear: assert property (p_gc_clear)
    else $error("general call survived start or stop");

  property p_lrb;
    rise_w |=> lrb_ff == $past(sda_s);
  endproperty
  a_lrb: assert property (p_lrb)
    else $error("last bit not captured");

  property p_stretch;
    iface_ff && !pause_ff |-> o_scl_oe;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock not held while paused");

  property p_no_detect;
    i_addr_detect_disable && !i_free_format_select |-> !aas_set_w && !gc_set_w;
  endproperty
  a_no_detect: assert property (p_no_detect)
    else $error("detection while disabled");

  c_soft_reset: cover property (sw_reset_w);
  c_al_set:     cover property (al_set_w);
  c_addressed:  cover property (eval_w && addr_hit_w && match_w);
  c_gcall:      cover property (gc_set_w);
endmodule : i2c_bus_control_status

// ==== src/i2c_ctl_map.svh ====
/*
  Constants for the serial bus control and status block: soft reset
  codes, word sizes, reset values and the clock period tables.
  Assumes the block clock is the peripheral clock the periods count in.
*/
`ifndef I2C_CTL_MAP_SVH
`define I2C_CTL_MAP_SVH

`define SOFT_RESET_FIELD_ARM   2'h2
`define SOFT_RESET_FIELD_FIRE  2'h1
`define PAUSE_RST   1'h1
`define WORD_BITS   4'h8
`define GCALL_BYTE  8'h00

`define LOW_N0  9'h00C
`define LOW_N1  9'h00E
`define LOW_N2  9'h012
`define LOW_N3  9'h01A
`define LOW_N4  9'h02A
`define LOW_N5  9'h04A
`define LOW_N6  9'h08A
`define LOW_N7  9'h10A

`define HIGH_M0 9'h009
`define HIGH_M1 9'h00B
`define HIGH_M2 9'h00F
`define HIGH_M3 9'h017
`define HIGH_M4 9'h027
`define HIGH_M5 9'h047
`define HIGH_M6 9'h087
`define HIGH_M7 9'h107

`endif

// ==== src/i2c_ctl_pkg.sv ====
/*
  Types for the serial bus control and status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package i2c_ctl_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_DATA = 2'h1,
    PH_ACK  = 2'h3,
    PH_SKIP = 2'h2
  } phase_e;

  typedef logic [8:0] period_t;
endpackage : i2c_ctl_pkg

// ==== src/i2c_pin_sync.sv ====
/*
  Two flip-flop synchroniser for bus pin levels.
  Assumes the inputs are asynchronous; reset value is the idle level.
*/
`timescale 1ns/1ps
module i2c_pin_sync #(
  parameter int          W       = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_ff <= RST_VAL;
      o_sync  <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end
endmodule : i2c_pin_sync

// ==== testbench/i2c_bus_partner.sv ====
/*
  Bus master model for the serial bus block: start, stop, words with
  an acknowledge clock, and a clock release that waits out stretching.
  Assumes open drain wires with pull-ups built by the bench.
*/
`timescale 1ns/1ps
module i2c_bus_partner #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic i_clk,
  // Wire levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Pull-down drives and hang flag
  output logic      o_scl_pull,
  output logic      o_sda_pull,
  output logic      o_hang
);
  initial begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
    o_hang     = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(negedge i_clk);
  endtask : half_wait

  // Release clock, wait while a device stretches it
  task automatic scl_up();
    int n;
    n = 0;
    o_scl_pull = 1'b0;
    @(negedge i_clk);
    while (i_scl !== 1'b1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 2000) o_hang = 1'b1;
    half_wait();
  endtask : scl_up

  task automatic bit_x(input logic b, output logic r);
    o_sda_pull = !b;
    half_wait();
    scl_up();
    r = i_sda;
    o_scl_pull = 1'b1;
  endtask : bit_x

  task automatic start_c();
    o_sda_pull = 1'b1;
    half_wait();
    o_scl_pull = 1'b1;
  endtask : start_c

  task automatic stop_c();
    o_sda_pull = 1'b1;
    half_wait();
    scl_up();
    o_sda_pull = 1'b0;
    half_wait();
  endtask : stop_c

  // Word MSB first, then an acknowledge clock with data released
  task automatic xfer(input logic [7:0] b, output logic [7:0] rd,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(b[i], rd[i]);
    bit_x(1'b1, ack);
  endtask : xfer
endmodule : i2c_bus_partner

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for the serial bus control and status block.
  Assumes the partner model as the only other master on the bus.
*/
`timescale 1ns/1ps
`include "i2c_ctl_map.svh"
module tb_top;
  logic       i_clk, i_rst_n, i_cr2_wr, i_wr_master_select;
  logic       i_wr_transmit_select, i_wr_pause, i_wr_iface_mode;
  logic [1:0] i_wr_soft_reset;
  logic       i_dbr_wr, i_dbr_rd, i_ack_count_en, i_addr_detect_disable;
  logic [7:0] i_dbr_wdata, o_rx_data, rd;
  logic [2:0] i_bit_count_field, i_clk_period_sel;
  logic [6:0] i_own_slave_address;
  logic       i_free_format_select, o_scl, o_scl_oe, o_sda, o_sda_oe;
  logic       o_iface_mode_select, o_master_select, o_transmit_select;
  logic       o_pause_flag, o_arb_lost_flag, o_addressed_as_slave_flag;
  logic       o_general_call_flag, o_last_rx_bit, o_bus_busy_flag;
  logic       o_transfer_irq, scl_pull, sda_pull, hang, ack;
  logic [5:0] row_in [10];
  logic [3:0] row_exp [10];
  int         failures, compares, irqs, leaks, n;
  wire        i_scl = !(o_scl_oe | scl_pull);
  wire        i_sda = !(o_sda_oe | sda_pull);

  i2c_bus_control_status dut (
    .i_clk, .i_rst_n, .i_cr2_wr, .i_wr_master_select,
    .i_wr_transmit_select, .i_wr_pause, .i_wr_iface_mode,
    .i_wr_soft_reset, .i_dbr_wr, .i_dbr_wdata, .i_dbr_rd,
    .i_ack_count_en, .i_addr_detect_disable, .i_bit_count_field,
    .i_clk_period_sel, .i_own_slave_address, .i_free_format_select,
    .i_scl, .o_scl, .o_scl_oe, .i_sda, .o_sda, .o_sda_oe,
    .o_iface_mode_select, .o_master_select, .o_transmit_select,
    .o_pause_flag, .o_arb_lost_flag, .o_addressed_as_slave_flag,
    .o_general_call_flag, .o_last_rx_bit, .o_bus_busy_flag,
    .o_rx_data, .o_transfer_irq
  );

  i2c_bus_partner bus (
    .i_clk(i_clk), .i_scl(i_scl), .i_sda(i_sda),
    .o_scl_pull(scl_pull), .o_sda_pull(sda_pull), .o_hang(hang)
  );

  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  // Interrupt pulses and data drive while arbitration is lost
  always @(negedge i_clk) begin
    if (o_transfer_irq === 1'b1) irqs++;
    if (o_arb_lost_flag === 1'b1 && o_sda_oe === 1'b1) leaks++;
  end

  always @(posedge hang) begin
    failures++;
    report_and_stop();
  end

  task automatic report_and_stop();
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_bit(string nm, logic e, logic g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_byte(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte

  // Control register two write: mode, master, transmit, pause, reset
  task automatic cr2(logic [5:0] v);
    @(negedge i_clk);
    {i_wr_iface_mode, i_wr_master_select, i_wr_transmit_select,
     i_wr_pause, i_wr_soft_reset} = v;
    i_cr2_wr = 1'b1;
    @(negedge i_clk);
    i_cr2_wr = 1'b0;
    @(negedge i_clk);
  endtask : cr2

  task automatic buf_op(logic wr, logic [7:0] d);
    @(negedge i_clk);
    i_dbr_wdata = d;
    i_dbr_wr = wr;
    i_dbr_rd = !wr;
    @(negedge i_clk);
    i_dbr_wr = 1'b0;
    i_dbr_rd = 1'b0;
    @(negedge i_clk);
  endtask : buf_op

  // Data write, then count cycles until the clock line is let go
  task automatic resume(logic [7:0] d);
    @(negedge i_clk);
    i_dbr_wdata = d;
    i_dbr_wr = 1'b1;
    @(negedge i_clk);
    i_dbr_wr = 1'b0;
    n = 0;
    while (o_scl_oe === 1'b1 && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 1000) begin
      failures++;
      report_and_stop();
    end
  endtask : resume

  task automatic settle();
    repeat (10) @(negedge i_clk);
  endtask : settle

  initial begin
    {i_rst_n, i_cr2_wr, i_wr_master_select, i_wr_transmit_select,
     i_wr_pause, i_wr_iface_mode, i_wr_soft_reset, i_dbr_wr, i_dbr_rd,
     i_dbr_wdata, i_addr_detect_disable, i_bit_count_field,
     i_clk_period_sel, i_free_format_select} = '0;
    i_ack_count_en = 1'b1;
    i_own_slave_address = 7'h50;
    row_in  = '{6'h18, 6'h24, 6'h38, 6'h3E, 6'h3D,
                6'h35, 6'h3E, 6'h3C, 6'h3D, 6'h24};
    row_exp = '{4'h1, 4'h9, 4'hF, 4'hF, 4'h9,
                4'hD, 4'hF, 4'hF, 4'hF, 4'h9};
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    cmp_bit("pause_rst", 1'b1, o_pause_flag);
    cmp_byte("flags_rst", 8'h00, {o_iface_mode_select, o_master_select,
             o_transmit_select, o_arb_lost_flag,
             o_addressed_as_slave_flag, o_general_call_flag,
             o_scl_oe, o_sda_oe});
    cmp_byte("rx_rst", 8'h00, o_rx_data);
    cmp_byte("misc_rst", 8'h00, {3'h0, o_scl, o_sda, o_last_rx_bit,
             o_bus_busy_flag, o_transfer_irq});
    // Port mode traffic
    bus.start_c();
    bus.xfer(8'hA0, rd, ack);
    cmp_bit("port_ack", 1'b1, ack);
    cmp_bit("port_busy", 1'b0, o_bus_busy_flag);
    bus.stop_c();
    // Set-up while the bus is idle
    cmp_bit("lines_high", 1'b1, i_scl & i_sda);
    for (int i = 0; i < 10; i++) begin
      cr2(row_in[i]);
      cmp_byte("cr2_row", {4'h0, row_exp[i]}, {4'h0, o_iface_mode_select,
               o_master_select, o_transmit_select, o_pause_flag});
    end
    // Detection disabled: general call ignored
    i_addr_detect_disable = 1'b1;
    bus.start_c();
    bus.xfer(8'h00, rd, ack);
    cmp_bit("dis_ack", 1'b1, ack);
    bus.stop_c();
    cmp_byte("dis_flags", 8'h00, {6'h00, o_addressed_as_slave_flag,
             o_general_call_flag});
    i_addr_detect_disable = 1'b0;
    // Own address, stretch, resume, one data word
    bus.start_c();
    settle();
    cmp_bit("busy", 1'b1, o_bus_busy_flag);
    bus.xfer(8'hA0, rd, ack);
    cmp_bit("addr_ack", 1'b0, ack);
    settle();
    cmp_bit("aas", 1'b1, o_addressed_as_slave_flag);
    cmp_bit("gc_own", 1'b0, o_general_call_flag);
    cmp_bit("lrb_ack", 1'b0, o_last_rx_bit);
    cmp_bit("hold", 1'b1, o_scl_oe & !o_pause_flag);
    cmp_byte("irqs", 8'h01, irqs[7:0]);
    cr2(6'h20);
    cmp_bit("pause_sw0", 1'b0, o_pause_flag);
    resume(8'h00);
    cmp_bit("pause_set", 1'b1, o_pause_flag);
    cmp_bit("release", 1'b1, n >= `LOW_N0 && n <= `LOW_N0 + 2);
    bus.xfer(8'h5A, rd, ack);
    settle();
    cmp_bit("data_ack", 1'b0, ack);
    cmp_byte("rx_data", 8'h5A, o_rx_data);
    resume(8'h00);
    bus.stop_c();
    settle();
    cmp_bit("busy_stop", 1'b0, o_bus_busy_flag);
    // General call then stop
    bus.start_c();
    bus.xfer(8'h00, rd, ack);
    settle();
    cmp_bit("gc_set", 1'b1, o_general_call_flag);
    cmp_bit("gc_aas", 1'b1, o_addressed_as_slave_flag);
    resume(8'h00);
    bus.stop_c();
    settle();
    cmp_bit("gc_stop", 1'b0, o_general_call_flag);
    // Free format: read bit taken as data
    i_free_format_select = 1'b1;
    bus.start_c();
    bus.xfer(8'hA1, rd, ack);
    settle();
    cmp_bit("ff_aas", 1'b1, o_addressed_as_slave_flag);
    cmp_bit("ff_trx", 1'b0, o_transmit_select);
    cmp_byte("ff_data", 8'hA1, o_rx_data);
    buf_op(1'b0, 8'h00);
    cmp_bit("ff_rd_clr", 1'b0, o_addressed_as_slave_flag);
    resume(8'h00);
    bus.stop_c();
    i_free_format_select = 1'b0;
    // Arbitration lost on the first bit
    cr2(6'h3C);
    buf_op(1'b1, 8'hA0);
    bus.start_c();
    bus.xfer(8'h20, rd, ack);
    settle();
    cmp_byte("arb", 8'h04, {5'h00, o_arb_lost_flag, o_master_select,
             o_transmit_select});
    cmp_bit("arb_hold", 1'b1, o_scl_oe & !o_pause_flag);
    cmp_byte("arb_leak", 8'h00, leaks[7:0]);
    cr2(6'h24);
    cmp_bit("arb_clr", 1'b0, o_arb_lost_flag);
    bus.stop_c();
    report_and_stop();
  end
endmodule : tb_top
